/* hw/dtc_pkg.sv */
package dtc_pkg;
	// special function register addresses
	localparam logic [7:0] ADDR_CTRL_FLAGS = 8'h88;
	localparam logic [7:0] ADDR_MODE_SEL = 8'h89;
	localparam logic [7:0] ADDR_CH0_LO = 8'h8A;
	localparam logic [7:0] ADDR_CH1_LO = 8'h8B;
	localparam logic [7:0] ADDR_CH0_HI = 8'h8C;
	localparam logic [7:0] ADDR_CH1_HI = 8'h8D;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	// timer_control_flags bit positions
	localparam int CF_CH1_OVF = 7;
	localparam int CF_CH1_RUN = 6;
	localparam int CF_CH0_OVF = 5;
	localparam int CF_CH0_RUN = 4;
	localparam int CF_IRQ1_FLAG = 3;
	localparam int CF_IRQ1_TYPE = 2;
	localparam int CF_IRQ0_FLAG = 1;
	localparam int CF_IRQ0_TYPE = 0;

	// timer_mode_select field positions
	localparam int MS_CH1_GATE = 7;
	localparam int MS_CH1_CT = 6;
	localparam int MS_CH1_MODE_HI = 5;
	localparam int MS_CH1_MODE_LO = 4;
	localparam int MS_CH0_GATE = 3;
	localparam int MS_CH0_CT = 2;
	localparam int MS_CH0_MODE_HI = 1;
	localparam int MS_CH0_MODE_LO = 0;

	localparam logic [7:0] CTRL_FLAGS_RST = 8'h00;
	localparam logic [7:0] MODE_SEL_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;

	// one machine cycle is twelve processor clocks
	localparam int MC_CLK_CYCLES = 12;
	localparam logic [3:0] MC_LAST = 4'(MC_CLK_CYCLES - 1);

	localparam logic [4:0] LO13_MASK = 5'h1F;

	typedef enum logic [1:0] {
		DTC_MODE_13,
		DTC_MODE_16,
		DTC_MODE_RELOAD,
		DTC_MODE_SPLIT
	} dtc_mode_t;
endpackage

/* hw/dtc_chan_if.sv */
`timescale 1ns/1ps
interface dtc_chan_if;
	import dtc_pkg::*;
	dtc_mode_t mode;
	logic split_en;
	logic inc_lo;
	logic inc_hi;
	logic wr_lo;
	logic wr_hi;
	logic [7:0] wdata;
	logic [7:0] lo;
	logic [7:0] hi;
	logic ovf_lo;
	logic ovf_hi;

	modport ctrl (
		output mode, split_en, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
		input lo, hi, ovf_lo, ovf_hi
	);
	modport chan (
		input mode, split_en, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
		output lo, hi, ovf_lo, ovf_hi
	);
endinterface

/* hw/dtc_channel.sv */
`timescale 1ns/1ps
module dtc_channel
	import dtc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	dtc_chan_if.chan cif
);
	logic [7:0] lo_ff;
	logic [7:0] hi_ff;
	logic [7:0] nxt_lo;
	logic [7:0] nxt_hi;
	logic ovf_lo;
	logic ovf_hi;
	logic [13:0] sum13;
	logic [16:0] sum16;
	logic [8:0] sum_lo;
	logic [8:0] sum_hi;

	always_comb begin
		sum13 = {1'b0, hi_ff, lo_ff[4:0]} + 14'h0001;
		sum16 = {1'b0, hi_ff, lo_ff} + 17'h00001;
		sum_lo = {1'b0, lo_ff} + 9'h001;
		sum_hi = {1'b0, hi_ff} + 9'h001;
		nxt_lo = lo_ff;
		nxt_hi = hi_ff;
		ovf_lo = 1'b0;
		ovf_hi = 1'b0;
		case (cif.mode)
			DTC_MODE_13: begin
				if (cif.inc_lo) begin
					nxt_hi = sum13[12:5];
					nxt_lo = {3'h0, sum13[4:0]};
					ovf_lo = sum13[13];
				end
			end
			DTC_MODE_16: begin
				if (cif.inc_lo) begin
					{nxt_hi, nxt_lo} = sum16[15:0];
					ovf_lo = sum16[16];
				end
			end
			DTC_MODE_RELOAD: begin
				if (cif.inc_lo) begin
					nxt_lo = sum_lo[8] ? hi_ff : sum_lo[7:0];
					ovf_lo = sum_lo[8];
				end
			end
			DTC_MODE_SPLIT: begin
				// only the split channel counts; the other one stops
				if (cif.split_en) begin
					if (cif.inc_lo) begin
						nxt_lo = sum_lo[7:0];
						ovf_lo = sum_lo[8];
					end
					if (cif.inc_hi) begin
						nxt_hi = sum_hi[7:0];
						ovf_hi = sum_hi[8];
					end
				end
			end
			default: begin
				nxt_lo = lo_ff;
			end
		endcase
		// software write to a byte wins over a count of that byte
		if (cif.wr_lo) begin
			nxt_lo = cif.wdata;
		end
		if (cif.wr_hi) begin
			nxt_hi = cif.wdata;
		end
		if (cif.mode == DTC_MODE_13) begin
			nxt_lo[7:5] = 3'h0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			lo_ff <= COUNT_RST;
			hi_ff <= COUNT_RST;
		end else begin
			lo_ff <= nxt_lo;
			hi_ff <= nxt_hi;
		end
	end

	assign cif.lo = lo_ff;
	assign cif.hi = hi_ff;
	assign cif.ovf_lo = ovf_lo;
	assign cif.ovf_hi = ovf_hi;
endmodule

/* hw/dtc_top.sv */
// Summary of operation
// - channel 1 gated: counts only with run bit set, qualified by its gating input.
// - channel 0 gated: counts only with run bit set, qualified by its gating input.
// - gated and running, a channel advances once per falling edge of its input.
// - count/time select bit: 1 counts external edges, 0 counts machine cycles unless the gate bit is set.
// - each channel has a two-bit mode field in the mode register.
// - channel 1 overflow sets control bit 7.
// - channel 0 overflow sets control bit 5.
// - overflow flags cleared by software write or by interrupt acknowledge.
// - channel 1 runs only while control bit 6 is set, else holds.
// - channel 0 runs only while control bit 4 is set, else holds.
// - falling edge on external interrupt 1 input sets control bit 3.
// - falling edge on external interrupt 0 input sets control bit 1.
// - external interrupt flags cleared by hardware on interrupt acknowledge.
// - control bit 2 picks edge or low-level trigger for interrupt 1.
// - control bit 0 picks edge or low-level trigger for interrupt 0.
// - modes: 13-bit, 16-bit, 8-bit reload from high byte, stop or split.
// - timer counts every twelve clocks; an input edge takes two machine cycles.
// - type bit 0 means low level, 1 means falling edge.
// - split: low byte uses channel 0 controls, high byte channel 1 run and flag.
`timescale 1ns/1ps
module dtc_top
	import dtc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic chan0_gate_in_i,
	input wire logic chan1_gate_in_i,
	input wire logic ext_irq0_input_i,
	input wire logic ext_irq1_input_i,
	input wire logic chan0_ack_i,
	input wire logic chan1_ack_i,
	input wire logic ext_irq0_ack_i,
	input wire logic ext_irq1_ack_i,
	output logic chan0_overflow_flag_o,
	output logic chan1_overflow_flag_o,
	output logic ext_irq0_edge_flag_o,
	output logic ext_irq1_edge_flag_o
);
	logic [7:0] timer_mode_select_ff;
	logic chan1_overflow_flag_ff;
	logic chan1_run_bit_ff;
	logic chan0_overflow_flag_ff;
	logic chan0_run_bit_ff;
	logic ext_irq1_edge_flag_ff;
	logic ext_irq1_type_bit_ff;
	logic ext_irq0_edge_flag_ff;
	logic ext_irq0_type_bit_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic [7:0] ctrl_flags_view;

	logic [3:0] mc_cnt_ff;
	logic mc_tick;

	logic [1:0] gate_smp_ff;
	logic [1:0] gate_prev_ff;
	logic [1:0] gate_fall;
	logic [1:0] irq_prev_ff;
	logic [1:0] irq_fall;

	logic wr_ctrl;
	logic wr_mode;
	logic ch0_gate;
	logic ch1_gate;
	logic ch0_ct;
	logic ch1_ct;
	dtc_mode_t ch0_mode;
	dtc_mode_t ch1_mode;
	logic ch0_split;
	logic ch0_evt;
	logic ch1_evt;
	logic ch0_ovf_set;
	logic ch1_ovf_set;
	logic irq0_set;
	logic irq1_set;

	dtc_chan_if ch0_if ();
	dtc_chan_if ch1_if ();

	assign wr_ctrl = sfr_wr_i && (sfr_addr_i == ADDR_CTRL_FLAGS);
	assign wr_mode = sfr_wr_i && (sfr_addr_i == ADDR_MODE_SEL);

	assign ch1_gate = timer_mode_select_ff[MS_CH1_GATE];
	assign ch0_gate = timer_mode_select_ff[MS_CH0_GATE];
	assign ch1_ct = timer_mode_select_ff[MS_CH1_CT];
	assign ch0_ct = timer_mode_select_ff[MS_CH0_CT];
	assign ch1_mode = dtc_mode_t'(timer_mode_select_ff[MS_CH1_MODE_HI:MS_CH1_MODE_LO]);
	assign ch0_mode = dtc_mode_t'(timer_mode_select_ff[MS_CH0_MODE_HI:MS_CH0_MODE_LO]);
	assign ch0_split = (ch0_mode == DTC_MODE_SPLIT);

	// machine cycle prescaler
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			mc_cnt_ff <= 4'h0;
		end else if (mc_cnt_ff == MC_LAST) begin
			mc_cnt_ff <= 4'h0;
		end else begin
			mc_cnt_ff <= mc_cnt_ff + 4'h1;
		end
	end

	assign mc_tick = (mc_cnt_ff == MC_LAST);

	// gating inputs are sampled once per machine cycle, so a falling edge
	// needs a high sample then a low sample: two machine cycles to recognise
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			gate_smp_ff <= 2'h3;
			gate_prev_ff <= 2'h3;
		end else if (mc_tick) begin
			gate_smp_ff <= {chan1_gate_in_i, chan0_gate_in_i};
			gate_prev_ff <= gate_smp_ff;
		end
	end

	// fires once, in the tick after the low sample was taken
	assign gate_fall = (mc_tick) ? (gate_prev_ff & ~gate_smp_ff) : 2'h0;

	// count event selection per channel
	always_comb begin
		if (ch0_gate) begin
			ch0_evt = gate_fall[0];
		end else if (ch0_ct) begin
			ch0_evt = gate_fall[0];
		end else begin
			ch0_evt = mc_tick;
		end
		if (ch1_gate) begin
			ch1_evt = gate_fall[1];
		end else if (ch1_ct) begin
			ch1_evt = gate_fall[1];
		end else begin
			ch1_evt = mc_tick;
		end
	end

	// channel 0
	assign ch0_if.mode = ch0_mode;
	assign ch0_if.split_en = 1'b1;
	assign ch0_if.inc_lo = chan0_run_bit_ff && ch0_evt;
	// split high byte times machine cycles under the channel 1 run bit
	assign ch0_if.inc_hi = chan1_run_bit_ff && mc_tick;
	assign ch0_if.wr_lo = sfr_wr_i && (sfr_addr_i == ADDR_CH0_LO);
	assign ch0_if.wr_hi = sfr_wr_i && (sfr_addr_i == ADDR_CH0_HI);
	assign ch0_if.wdata = sfr_wdata_i;

	// channel 1; its own split mode means stop
	assign ch1_if.mode = ch1_mode;
	assign ch1_if.split_en = 1'b0;
	assign ch1_if.inc_lo = chan1_run_bit_ff && ch1_evt;
	assign ch1_if.inc_hi = 1'b0;
	assign ch1_if.wr_lo = sfr_wr_i && (sfr_addr_i == ADDR_CH1_LO);
	assign ch1_if.wr_hi = sfr_wr_i && (sfr_addr_i == ADDR_CH1_HI);
	assign ch1_if.wdata = sfr_wdata_i;

	dtc_channel u_ch0 (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.cif(ch0_if.chan)
	);

	dtc_channel u_ch1 (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.cif(ch1_if.chan)
	);

	assign ch0_ovf_set = ch0_if.ovf_lo;
	// while channel 0 is split, its high byte owns the channel 1 flag
	assign ch1_ovf_set = ch0_split ? ch0_if.ovf_hi : ch1_if.ovf_lo;

	// mode register
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			timer_mode_select_ff <= MODE_SEL_RST;
		end else if (wr_mode) begin
			timer_mode_select_ff <= sfr_wdata_i;
		end
	end

	// run and type bits, software only
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			chan1_run_bit_ff <= CTRL_FLAGS_RST[CF_CH1_RUN];
			chan0_run_bit_ff <= CTRL_FLAGS_RST[CF_CH0_RUN];
			ext_irq1_type_bit_ff <= CTRL_FLAGS_RST[CF_IRQ1_TYPE];
			ext_irq0_type_bit_ff <= CTRL_FLAGS_RST[CF_IRQ0_TYPE];
		end else if (wr_ctrl) begin
			chan1_run_bit_ff <= sfr_wdata_i[CF_CH1_RUN];
			chan0_run_bit_ff <= sfr_wdata_i[CF_CH0_RUN];
			ext_irq1_type_bit_ff <= sfr_wdata_i[CF_IRQ1_TYPE];
			ext_irq0_type_bit_ff <= sfr_wdata_i[CF_IRQ0_TYPE];
		end
	end

	// overflow flags: a hardware set wins over a write or an acknowledge
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			chan1_overflow_flag_ff <= CTRL_FLAGS_RST[CF_CH1_OVF];
			chan0_overflow_flag_ff <= CTRL_FLAGS_RST[CF_CH0_OVF];
		end else begin
			if (ch1_ovf_set) begin
				chan1_overflow_flag_ff <= 1'b1;
			end else if (wr_ctrl) begin
				chan1_overflow_flag_ff <= sfr_wdata_i[CF_CH1_OVF];
			end else if (chan1_ack_i) begin
				chan1_overflow_flag_ff <= 1'b0;
			end
			if (ch0_ovf_set) begin
				chan0_overflow_flag_ff <= 1'b1;
			end else if (wr_ctrl) begin
				chan0_overflow_flag_ff <= sfr_wdata_i[CF_CH0_OVF];
			end else if (chan0_ack_i) begin
				chan0_overflow_flag_ff <= 1'b0;
			end
		end
	end

	// external interrupt inputs, previous level for edge detection
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			irq_prev_ff <= 2'h3;
		end else begin
			irq_prev_ff <= {ext_irq1_input_i, ext_irq0_input_i};
		end
	end

	assign irq_fall = irq_prev_ff & ~{ext_irq1_input_i, ext_irq0_input_i};

	// level mode keeps requesting while the input is low
	assign irq1_set = ext_irq1_type_bit_ff ? irq_fall[1] : !ext_irq1_input_i;
	assign irq0_set = ext_irq0_type_bit_ff ? irq_fall[0] : !ext_irq0_input_i;

	// interrupt flags: set wins over a write or an acknowledge
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ext_irq1_edge_flag_ff <= CTRL_FLAGS_RST[CF_IRQ1_FLAG];
			ext_irq0_edge_flag_ff <= CTRL_FLAGS_RST[CF_IRQ0_FLAG];
		end else begin
			if (irq1_set) begin
				ext_irq1_edge_flag_ff <= 1'b1;
			end else if (wr_ctrl) begin
				ext_irq1_edge_flag_ff <= sfr_wdata_i[CF_IRQ1_FLAG];
			end else if (ext_irq1_ack_i) begin
				ext_irq1_edge_flag_ff <= 1'b0;
			end
			if (irq0_set) begin
				ext_irq0_edge_flag_ff <= 1'b1;
			end else if (wr_ctrl) begin
				ext_irq0_edge_flag_ff <= sfr_wdata_i[CF_IRQ0_FLAG];
			end else if (ext_irq0_ack_i) begin
				ext_irq0_edge_flag_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		ctrl_flags_view = 8'h00;
		ctrl_flags_view[CF_CH1_OVF] = chan1_overflow_flag_ff;
		ctrl_flags_view[CF_CH1_RUN] = chan1_run_bit_ff;
		ctrl_flags_view[CF_CH0_OVF] = chan0_overflow_flag_ff;
		ctrl_flags_view[CF_CH0_RUN] = chan0_run_bit_ff;
		ctrl_flags_view[CF_IRQ1_FLAG] = ext_irq1_edge_flag_ff;
		ctrl_flags_view[CF_IRQ1_TYPE] = ext_irq1_type_bit_ff;
		ctrl_flags_view[CF_IRQ0_FLAG] = ext_irq0_edge_flag_ff;
		ctrl_flags_view[CF_IRQ0_TYPE] = ext_irq0_type_bit_ff;
	end

	always_comb begin
		case (sfr_addr_i)
			ADDR_CTRL_FLAGS: nxt_rdata = ctrl_flags_view;
			ADDR_MODE_SEL: nxt_rdata = timer_mode_select_ff;
			ADDR_CH0_LO: nxt_rdata = ch0_if.lo;
			ADDR_CH1_LO: nxt_rdata = ch1_if.lo;
			ADDR_CH0_HI: nxt_rdata = ch0_if.hi;
			ADDR_CH1_HI: nxt_rdata = ch1_if.hi;
			default: nxt_rdata = RDATA_UNMAPPED;
		endcase
	end

	// read data is registered; it holds until the next read
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rdata_ff <= RDATA_UNMAPPED;
		end else if (sfr_rd_i) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign sfr_rdata_o = rdata_ff;
	assign chan0_overflow_flag_o = chan0_overflow_flag_ff;
	assign chan1_overflow_flag_o = chan1_overflow_flag_ff;
	assign ext_irq0_edge_flag_o = ext_irq0_edge_flag_ff;
	assign ext_irq1_edge_flag_o = ext_irq1_edge_flag_ff;
endmodule

/* tb/dtc_checker.sv */
`timescale 1ns/1ps
module dtc_checker
	import dtc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic chan0_gate_in_i,
	input wire logic chan1_gate_in_i,
	input wire logic ext_irq0_input_i,
	input wire logic ext_irq1_input_i,
	input wire logic chan0_ack_i,
	input wire logic chan1_ack_i,
	input wire logic ext_irq0_ack_i,
	input wire logic ext_irq1_ack_i,
	input wire logic chan0_overflow_flag_o,
	input wire logic chan1_overflow_flag_o,
	input wire logic ext_irq0_edge_flag_o,
	input wire logic ext_irq1_edge_flag_o
);
	logic [3:0] mc_ff;
	logic tick;
	logic cf_wr;
	// mirrors the prescaler from reset release, so overflow can be pinned to ticks
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			mc_ff <= 4'h0;
		end else begin
			mc_ff <= (mc_ff == MC_LAST) ? 4'h0 : mc_ff + 4'h1;
		end
	end
	assign tick = (mc_ff == MC_LAST);
	assign cf_wr = sfr_wr_i && (sfr_addr_i == ADDR_CTRL_FLAGS);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_ovf0_sticky: assert property (
		chan0_overflow_flag_o && !chan0_ack_i && !cf_wr |=> chan0_overflow_flag_o)
		else $error("channel 0 overflow flag dropped without cause");
	a_ovf1_sticky: assert property (
		chan1_overflow_flag_o && !chan1_ack_i && !cf_wr |=> chan1_overflow_flag_o)
		else $error("channel 1 overflow flag dropped without cause");
	a_irq0_sticky: assert property (
		ext_irq0_edge_flag_o && !ext_irq0_ack_i && !cf_wr |=> ext_irq0_edge_flag_o)
		else $error("interrupt 0 flag dropped without cause");
	a_irq1_sticky: assert property (
		ext_irq1_edge_flag_o && !ext_irq1_ack_i && !cf_wr |=> ext_irq1_edge_flag_o)
		else $error("interrupt 1 flag dropped without cause");
	a_irq0_fall_sets: assert property (
		$fell(ext_irq0_input_i) |=> ext_irq0_edge_flag_o)
		else $error("interrupt 0 fall did not set flag");
	a_irq1_fall_sets: assert property (
		$fell(ext_irq1_input_i) |=> ext_irq1_edge_flag_o)
		else $error("interrupt 1 fall did not set flag");
	a_ovf0_on_tick: assert property (
		$rose(chan0_overflow_flag_o) |-> $past(tick) || $past(cf_wr))
		else $error("channel 0 overflow rose off a machine tick");
	a_ovf1_on_tick: assert property (
		$rose(chan1_overflow_flag_o) |-> $past(tick) || $past(cf_wr))
		else $error("channel 1 overflow rose off a machine tick");
endmodule

bind dtc_top dtc_checker u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
	.sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .chan0_gate_in_i(chan0_gate_in_i),
	.chan1_gate_in_i(chan1_gate_in_i), .ext_irq0_input_i(ext_irq0_input_i),
	.ext_irq1_input_i(ext_irq1_input_i), .chan0_ack_i(chan0_ack_i),
	.chan1_ack_i(chan1_ack_i), .ext_irq0_ack_i(ext_irq0_ack_i),
	.ext_irq1_ack_i(ext_irq1_ack_i), .chan0_overflow_flag_o(chan0_overflow_flag_o),
	.chan1_overflow_flag_o(chan1_overflow_flag_o),
	.ext_irq0_edge_flag_o(ext_irq0_edge_flag_o),
	.ext_irq1_edge_flag_o(ext_irq1_edge_flag_o));

/* tb/dual_timer_counter_control_bench.sv */
`timescale 1ns/1ps
module dual_timer_counter_control_bench;
	import dtc_pkg::*;
	logic core_clk_i = 1'b0, rst_n_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, rnd_on = 1'b0;
	logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
	logic [1:0] gate_i = 2'b11, irq_i = 2'b11, m_gs, m_gp, m_ip;
	logic [3:0] ack_i = 4'h0;
	logic ovf0_o, ovf1_o, ie0_o, ie1_o;
	logic [7:0] m_tc, m_tm, m_rd, m_lo[2], m_hi[2];
	int m_pc, n_fail = 0, checks_done = 0, cyc = 0;

	dtc_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
		.sfr_rdata_o(sfr_rdata_o), .chan0_gate_in_i(gate_i[0]), .chan1_gate_in_i(gate_i[1]),
		.ext_irq0_input_i(irq_i[0]), .ext_irq1_input_i(irq_i[1]), .chan0_ack_i(ack_i[0]),
		.chan1_ack_i(ack_i[1]), .ext_irq0_ack_i(ack_i[2]), .ext_irq1_ack_i(ack_i[3]),
		.chan0_overflow_flag_o(ovf0_o), .chan1_overflow_flag_o(ovf1_o),
		.ext_irq0_edge_flag_o(ie0_o), .ext_irq1_edge_flag_o(ie1_o));

	initial begin
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic check(input string nm, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask

	task automatic acc(input logic w, input logic [7:0] a, d);
		@(posedge core_clk_i);
		sfr_wr_i <= w;
		sfr_rd_i <= !w;
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		@(posedge core_clk_i);
		sfr_wr_i <= 1'b0;
		sfr_rd_i <= 1'b0;
	endtask

	task automatic rd_all();
		for (int a = 8'h88; a < 8'h8F; a++) acc(1'b0, 8'(a), 8'h00);
	endtask

	task automatic pulse_ack(input logic [3:0] v);
		@(posedge core_clk_i);
		ack_i <= v;
		@(posedge core_clk_i);
		ack_i <= 4'h0;
	endtask

	task automatic do_reset();
		rst_n_i <= 1'b0;
		wt(5);
		rst_n_i <= 1'b1;
	endtask

	function automatic logic [7:0] rd_val(input logic [7:0] a);
		case (a)
			ADDR_CTRL_FLAGS: return m_tc;
			ADDR_MODE_SEL: return m_tm;
			ADDR_CH0_LO, ADDR_CH1_LO: return m_lo[a[0]];
			ADDR_CH0_HI, ADDR_CH1_HI: return m_hi[a[0]];
			default: return RDATA_UNMAPPED;
		endcase
	endfunction

	// cycle model, sampling the same inputs at the same edge as the design
	always @(posedge core_clk_i) begin
		logic [16:0] t;
		logic [1:0] md, ov, es;
		logic w, en;
		if (!rst_n_i) begin
			{m_tc, m_tm, m_rd} = 24'h0;
			m_lo = '{8'h00, 8'h00};
			m_hi = '{8'h00, 8'h00};
			m_pc = 0;
			m_gs = 2'b11;
			m_gp = 2'b11;
			m_ip = 2'b11;
		end else begin
			if (sfr_rd_i) m_rd = rd_val(sfr_addr_i);
			ov = 2'b00;
			for (int i = 0; i < 2; i++) begin
				es[i] = m_tc[2 * i] ? m_ip[i] && !irq_i[i] : !irq_i[i];
			end
			m_ip = irq_i;
			if (m_pc == 11) begin
				for (int c = 0; c < 2; c++) begin
					md = m_tm[4 * c +: 2];
					// a fall counts one tick after its low sample was taken
					en = m_tc[4 + 2 * c] && (m_tm[4 * c + 2 +: 2] != 2'h0 ? m_gp[c] && !m_gs[c] : 1'b1);
					w = 1'b0;
					if (en && !(c == 1 && md == 2'h3)) begin
						case (md)
							2'h0: begin
								t = {4'h0, m_hi[c], m_lo[c][4:0]} + 17'h1;
								w = t[13];
								m_hi[c] = t[12:5];
								m_lo[c] = {3'h0, t[4:0]};
							end
							2'h1: begin
								t = {1'b0, m_hi[c], m_lo[c]} + 17'h1;
								w = t[16];
								{m_hi[c], m_lo[c]} = t[15:0];
							end
							2'h2: begin
								w = (m_lo[c] == 8'hFF);
								m_lo[c] = w ? m_hi[c] : m_lo[c] + 8'h01;
							end
							default: begin
								w = (m_lo[c] == 8'hFF);
								m_lo[c] = m_lo[c] + 8'h01;
							end
						endcase
					end
					ov[c] = w && !(c == 1 && m_tm[1:0] == 2'h3);
				end
				if (m_tm[1:0] == 2'h3 && m_tc[6]) begin
					ov[1] = (m_hi[0] == 8'hFF);
					m_hi[0] = m_hi[0] + 8'h01;
				end
				m_gp = m_gs;
				m_gs = gate_i;
			end
			m_pc = (m_pc == 11) ? 0 : m_pc + 1;
			if (sfr_wr_i) begin
				case (sfr_addr_i)
					ADDR_CTRL_FLAGS: m_tc = sfr_wdata_i;
					ADDR_MODE_SEL: m_tm = sfr_wdata_i;
					ADDR_CH0_LO, ADDR_CH1_LO: m_lo[sfr_addr_i[0]] = sfr_wdata_i;
					ADDR_CH0_HI, ADDR_CH1_HI: m_hi[sfr_addr_i[0]] = sfr_wdata_i;
					default: ;
				endcase
			end
			for (int c = 0; c < 2; c++) begin
				if (m_tm[4 * c +: 2] == 2'h0) m_lo[c][7:5] = 3'h0;
			end
			m_tc &= ~{ack_i[1], 1'b0, ack_i[0], 1'b0, ack_i[3], 1'b0, ack_i[2], 1'b0};
			// hardware set wins over both ack and write
			m_tc |= {ov[1], 1'b0, ov[0], 1'b0, es[1], 1'b0, es[0], 1'b0};
		end
	end

	always @(negedge core_clk_i) begin
		if (rst_n_i) begin
			check("rdata", sfr_rdata_o, m_rd);
			check("ovf0", ovf0_o, m_tc[5]);
			check("ovf1", ovf1_o, m_tc[7]);
			check("irq0", ie0_o, m_tc[1]);
			check("irq1", ie1_o, m_tc[3]);
		end
	end

	always @(posedge core_clk_i) begin
		if (rnd_on) gate_i <= 2'($urandom);
		cyc++;
		if (cyc == 10000) begin
			n_fail++;
			wrap_up();
		end
	end

	initial begin
		void'($urandom(42881));
		rnd_on = 1'b1;
		wt(5);
		rst_n_i <= 1'b1;
		rd_all();
		for (int c = 0; c < 2; c++) begin
			for (int md = 0; md < 4; md++) begin
				acc(1'b1, ADDR_MODE_SEL, 8'(md << (4 * c)));
				acc(1'b1, 8'(ADDR_CH0_LO + c), 8'hF0 | 8'($urandom_range(12, 15)));
				acc(1'b1, 8'(ADDR_CH0_HI + c), (md == 2) ? 8'hE0 : 8'hFF);
				acc(1'b1, ADDR_CTRL_FLAGS, c ? 8'h40 : (md == 3 ? 8'h50 : 8'h10));
				wt(70);
				rd_all();
				pulse_ack(c ? 4'h2 : 4'h1);
				acc(1'b1, ADDR_CTRL_FLAGS, 8'h00);
				wt(30);
				rd_all();
				acc(1'b1, 8'(ADDR_CH0_LO + c), 8'h00);
			end
		end
		for (int g = 4; g < 16; g += 4) begin
			acc(1'b1, ADDR_MODE_SEL, 8'((g + 1) * 17));
			acc(1'b1, ADDR_CTRL_FLAGS, 8'h50);
			wt(300);
			rd_all();
			acc(1'b1, ADDR_CTRL_FLAGS, 8'h00);
			wt(100);
			rd_all();
		end
		for (int t = 0; t < 2; t++) begin
			acc(1'b1, ADDR_CTRL_FLAGS, t ? 8'h05 : 8'h00);
			irq_i <= 2'b00;
			wt(3);
			pulse_ack(4'hC);
			irq_i <= 2'b11;
			wt(2);
			pulse_ack(4'hC);
			wt(2);
		end
		acc(1'b1, ADDR_CTRL_FLAGS, 8'hAA);
		acc(1'b0, ADDR_CTRL_FLAGS, 8'h00);
		acc(1'b1, ADDR_CTRL_FLAGS, 8'h00);
		acc(1'b1, ADDR_MODE_SEL, 8'h11);
		acc(1'b1, ADDR_CTRL_FLAGS, 8'h50);
		wt(40);
		do_reset();
		rd_all();
		wrap_up();
	end
endmodule
